// [byte_store.sv]
// One-packet byte memory with a registered read port.
// Assumes writer and reader never use the same word in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module byte_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 188,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (ce_i && we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule
`default_nettype wire

// [tb_ts_packet_out.sv]
// Self-checking bench for the transport packet output stage.
// Assumes the checker is bound and the sink model watches the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_ts_packet_out;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lock = 1'b0;
    logic in_valid = 1'b0;
    logic [7:0] in_data = 8'h00;
    logic in_uncorr = 1'b0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic inv = 1'b1;
    logic ext = 1'b0;
    logic ext_on = 1'b0;
    ts_out_pkg::mode_s mode = '0;
    logic in_ready, bclk, pstart, pvalid, pbk;
    logic [7:0] rdata, pdata, pkts, len, b0, b1o, blast, nbk;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    // User byte clock parks low when not in use
    always @(negedge clk) begin
        ext <= ext_on ? ~ext : 1'b0;
    end
    ts_packet_out ts_packet_out_i (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
        .SYMBOL_LOCK_I(lock), .MODE_I(mode), .EXT_CLK_I(ext),
        .IN_VALID_I(in_valid), .IN_DATA_I(in_data), .IN_UNCORR_I(in_uncorr),
        .IN_READY_O(in_ready), .REG_WE_I(we), .REG_RE_I(re),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .OUTPUT_BYTE_CLOCK_O(bclk), .PACKET_BYTE_OUT_O(pdata),
        .PACKET_START_STROBE_O(pstart), .PACKET_VALID_STROBE_O(pvalid),
        .BLOCK_ERROR_N_O(pbk));
    ts_sink_model ts_sink_model_i (.clk_i(clk), .rst_i(rst), .inv_i(inv),
        .byte_clk_i(bclk), .data_i(pdata), .start_i(pstart),
        .valid_i(pvalid), .bk_n_i(pbk), .pkts_o(pkts), .len_o(len),
        .b0_o(b0), .b1_o(b1o), .blast_o(blast), .nbk_o(nbk));
    task automatic finish_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        we = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        we = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        re = 1'b1;
        addr = a;
        @(negedge clk);
        re = 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask
    task automatic fill(input logic unc, input logic [7:0] v1);
        int k;
        k = 0;
        while (in_ready !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        for (k = 0; k < ts_out_pkg::PKT_BYTES; k++) begin
            in_valid = 1'b1;
            in_uncorr = unc;
            in_data = k == 0 ? 8'h47 : (k == 1 ? v1 : 8'(k));
            @(negedge clk);
        end
        in_valid = 1'b0;
        in_uncorr = 1'b0;
    endtask
    task automatic deliver(input logic unc, input logic [7:0] v1,
                           input logic [7:0] e1, input logic [7:0] ebk);
        logic [7:0] p0;
        int k;
        fill(unc, v1);
        p0 = pkts;
        k = 0;
        while (pkts === p0 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        check(pkts, p0 + 8'h01);
        check(len, 8'(ts_out_pkg::PKT_BYTES));
        check(b0, 8'h47);
        check(b1o, e1);
        check(blast, 8'hBB);
        check(nbk, ebk);
    endtask
    task automatic t_regs();
        rd(8'h50, 8'h01);
        rd(8'h5A, 8'h01);
        rd(8'h5B, 8'h01);
        rd(8'h3F, 8'h00);
    endtask
    // Packet matches the clean one, so a retained copy cannot confuse
    task automatic t_gated();
        fill(1'b0, 8'h00);
        repeat (800) @(negedge clk);
        check(pkts, 8'h00);
        rd(8'h5C, 8'h06);
        wr(8'h5B, 8'h00);
    endtask
    task automatic t_insert();
        deliver(1'b0, 8'h00, 8'h00, 8'h00);
        deliver(1'b1, 8'h00, 8'h80, 8'hBC);
    endtask
    task automatic t_pass();
        wr(8'h5A, 8'h00);
        // Lock lost mid-packet: that packet is dropped, pins go idle
        fill(1'b0, 8'h00);
        repeat (100) @(negedge clk);
        lock = 1'b0;
        repeat (20) @(negedge clk);
        check({7'h00, pvalid}, 8'h00);
        check(pdata, 8'h00);
        lock = 1'b1;
        deliver(1'b1, 8'h80, 8'h80, 8'hBC);
        mode.code_rate = 3'h1;
        deliver(1'b1, 8'h01, 8'h01, 8'hBC);
    endtask
    // Rising-edge launch, then the user clock
    task automatic t_modes();
        wr(8'h50, 8'h00);
        inv = 1'b0;
        deliver(1'b0, 8'h47, 8'h47, 8'h00);
        inv = 1'b1;
        wr(8'h50, 8'h03);
        ext_on = 1'b1;
        deliver(1'b1, 8'h00, 8'h00, 8'hBC);
        ext_on = 1'b0;
        wr(8'h50, 8'h01);
        rd(8'h50, 8'h01);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        // Invert select left at one for receiver hold margin
        lock = 1'b1;
        t_regs();
        t_gated();
        t_insert();
        t_pass();
        t_modes();
        finish_test();
    end
endmodule
`default_nettype wire

// [ts_out_pkg.sv]
// Constants and carrier types shared by the transport packet output stage.
// Assumes a 20 MHz core clock and a simple byte-wide register port.
`default_nettype none
package ts_out_pkg;
    localparam int PKT_BYTES = 188;
    localparam int CLK_HZ = 20000000;
    localparam logic [7:0] OUT_CLK_CTRL_OFF = 8'h50;
    localparam logic [7:0] OUT_CTRL_A_OFF = 8'h5A;
    localparam logic [7:0] CONFIG_OFF = 8'h5B;
    localparam logic [7:0] STATUS_OFF = 8'h5C;
    localparam int INV_BIT = 0;
    localparam int EXTCLK_BIT = 1;
    localparam int ERROR_FLAG_INSERT_ENABLE_BIT = 0;
    localparam int GATE_BIT = 0;
    localparam logic [7:0] OUT_CLK_CTRL_RST = 8'h01;
    localparam logic [7:0] OUT_CTRL_A_RST = 8'h01;
    localparam logic [7:0] CONFIG_RST = 8'h01;
    localparam logic [7:0] TEI_MASK = 8'h80;
    localparam int TEI_BYTE = 1;
    localparam logic [7:0] HALF_BASE = 8'h01;

    typedef struct packed {
        logic [1:0] guard;
        logic [1:0] constellation;
        logic [1:0] hierarchy;
        logic [2:0] code_rate;
    } mode_s;

    typedef struct packed {
        logic [7:0] data;
        logic start;
        logic valid;
        logic block_error_n;
    } ts_pins_s;

    typedef enum logic {
        ST_IDLE,
        ST_SEND
    } out_state_e;
endpackage
`default_nettype wire

// [ts_packet_out.sv]
// Transport packet output stage: buffers one decoded packet and sends it
// byte-wide with its own byte clock, start, valid and block-error strobes.
// Assumes the upstream decoder presents packet bytes synchronous to CLK_I.
// Behaviour
// - A packet leaves as 188 bytes on consecutive byte clocks, no gaps.
// - With insertion enabled, uncorrectable packets get the error indicator set.
// - With insertion disabled, the error indicator passes through unchanged.
// - Sync byte position moves at most one byte clock from nominal.
// - Byte clock runs continuously from the symbol clock once locked.
// - Invert select high: outputs change on falling byte-clock edge.
// - Data lines stay low between packets.
// - Start strobe is high only on the first byte of a packet.
// - Valid strobe is high from first byte through last byte.
// - Block error is low across a whole uncorrectable packet.
// - Invert select resets to one, in the clock control register at 0x50.
// - Byte clock rate is chosen automatically from the transmission mode.
// - A user-supplied output clock may replace the internal one.
`timescale 1ns/1ps
`default_nettype none
module ts_packet_out #(
    parameter int PKT_LEN = ts_out_pkg::PKT_BYTES
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic SYMBOL_LOCK_I,
    input wire ts_out_pkg::mode_s MODE_I,
    input wire logic EXT_CLK_I,
    input wire logic IN_VALID_I,
    input wire logic [7:0] IN_DATA_I,
    input wire logic IN_UNCORR_I,
    output logic IN_READY_O,
    input wire logic REG_WE_I,
    input wire logic REG_RE_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    output logic OUTPUT_BYTE_CLOCK_O,
    output logic [7:0] PACKET_BYTE_OUT_O,
    output logic PACKET_START_STROBE_O,
    output logic PACKET_VALID_STROBE_O,
    output logic BLOCK_ERROR_N_O
);
    localparam int AW = $clog2(PKT_LEN);
    localparam logic [AW-1:0] LAST_IDX = AW'(PKT_LEN - 1);

    logic [7:0] clk_ctrl_r;
    logic [7:0] ctrl_a_r;
    logic [7:0] config_r;
    logic clock_invert_select;
    logic ext_clk_sel;
    logic error_flag_insert_enable;
    logic stream_output_gate;

    logic [AW-1:0] wr_idx_r;
    logic pkt_full_r;
    logic uncorr_r;
    logic [AW-1:0] rd_idx_r;
    logic [7:0] rd_data;
    ts_out_pkg::out_state_e state_r;

    logic [7:0] half_cnt_r;
    logic [7:0] half_nxt;
    logic int_clk_r;
    logic ext_prev_r;
    logic rise_ev;
    logic fall_ev;
    logic launch;
    logic wr_en;
    logic start_ok;
    logic [7:0] byte_nxt;

    assign clock_invert_select = clk_ctrl_r[ts_out_pkg::INV_BIT];
    assign ext_clk_sel = clk_ctrl_r[ts_out_pkg::EXTCLK_BIT];
    assign error_flag_insert_enable = ctrl_a_r[ts_out_pkg::ERROR_FLAG_INSERT_ENABLE_BIT];
    assign stream_output_gate = config_r[ts_out_pkg::GATE_BIT];

    // Register writes
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            clk_ctrl_r <= ts_out_pkg::OUT_CLK_CTRL_RST;
            ctrl_a_r <= ts_out_pkg::OUT_CTRL_A_RST;
            config_r <= ts_out_pkg::CONFIG_RST;
        end else if (CE_I && REG_WE_I) begin
            unique case (REG_ADDR_I)
                ts_out_pkg::OUT_CLK_CTRL_OFF: clk_ctrl_r <= REG_WDATA_I;
                ts_out_pkg::OUT_CTRL_A_OFF: ctrl_a_r <= REG_WDATA_I;
                ts_out_pkg::CONFIG_OFF: config_r <= REG_WDATA_I;
                default: ;
            endcase
        end
    end

    // Register reads, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (CE_I && REG_RE_I) begin
            unique case (REG_ADDR_I)
                ts_out_pkg::OUT_CLK_CTRL_OFF: REG_RDATA_O <= clk_ctrl_r;
                ts_out_pkg::OUT_CTRL_A_OFF: REG_RDATA_O <= ctrl_a_r;
                ts_out_pkg::CONFIG_OFF: REG_RDATA_O <= config_r;
                ts_out_pkg::STATUS_OFF: REG_RDATA_O <= {5'h00, SYMBOL_LOCK_I,
                    pkt_full_r, state_r == ts_out_pkg::ST_SEND};
                default: REG_RDATA_O <= 8'h00;
            endcase
        end
    end

    // Half period grows with rate, constellation, hierarchy and guard to even out spacing
    always_comb begin
        half_nxt = ts_out_pkg::HALF_BASE + 8'(MODE_I.code_rate)
            + 8'(MODE_I.constellation) + 8'(MODE_I.hierarchy)
            + 8'(MODE_I.guard);
    end

    // Internal byte clock, free running while locked
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            half_cnt_r <= 8'h00;
            int_clk_r <= 1'b0;
        end else if (CE_I) begin
            if (!SYMBOL_LOCK_I) begin
                half_cnt_r <= 8'h00;
                int_clk_r <= 1'b0;
            end else if (half_cnt_r >= half_nxt - 8'h01) begin
                half_cnt_r <= 8'h00;
                int_clk_r <= ~int_clk_r;
            end else begin
                half_cnt_r <= half_cnt_r + 8'h01;
            end
        end
    end

    // User clock arrives synchronous; only its previous level is kept
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ext_prev_r <= 1'b0;
            OUTPUT_BYTE_CLOCK_O <= 1'b0;
        end else if (CE_I) begin
            ext_prev_r <= EXT_CLK_I;
            OUTPUT_BYTE_CLOCK_O <= ext_clk_sel ? EXT_CLK_I : int_clk_r;
        end
    end

    always_comb begin
        if (ext_clk_sel) begin
            rise_ev = EXT_CLK_I && !ext_prev_r;
            fall_ev = !EXT_CLK_I && ext_prev_r;
        end else begin
            rise_ev = !OUTPUT_BYTE_CLOCK_O && int_clk_r;
            fall_ev = OUTPUT_BYTE_CLOCK_O && !int_clk_r;
        end
        // Pins follow the selected clock one core cycle late, so the
        // launch edge of the pin and the data update stay aligned.
        launch = clock_invert_select ? fall_ev : rise_ev;
    end

    // Packet fill side
    assign wr_en = IN_VALID_I && IN_READY_O;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wr_idx_r <= '0;
            uncorr_r <= 1'b0;
        end else if (CE_I && wr_en) begin
            wr_idx_r <= (wr_idx_r == LAST_IDX) ? '0 : wr_idx_r + AW'(1);
            if (wr_idx_r == '0) begin
                uncorr_r <= IN_UNCORR_I;
            end else begin
                uncorr_r <= uncorr_r | IN_UNCORR_I;
            end
        end
    end

    assign start_ok = launch && pkt_full_r && !stream_output_gate
        && SYMBOL_LOCK_I;

    // Full flag: set by the last written byte, cleared when sent or dropped
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pkt_full_r <= 1'b0;
        end else if (CE_I) begin
            if (wr_en && wr_idx_r == LAST_IDX) begin
                pkt_full_r <= 1'b1;
            end else if (state_r == ts_out_pkg::ST_SEND && (!SYMBOL_LOCK_I
                    || (launch && (rd_idx_r == LAST_IDX
                    || stream_output_gate)))) begin
                pkt_full_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            IN_READY_O <= 1'b0;
        end else if (CE_I) begin
            IN_READY_O <= !pkt_full_r
                && !(wr_en && wr_idx_r == LAST_IDX);
        end
    end

    byte_store #(
        .WIDTH(8),
        .DEPTH(PKT_LEN),
        .AW(AW)
    ) u_store (
        .clk_i(CLK_I),
        .ce_i(CE_I),
        .we_i(wr_en),
        .waddr_i(wr_idx_r),
        .wdata_i(IN_DATA_I),
        .raddr_i(rd_idx_r),
        .rdata_o(rd_data)
    );

    // Error indicator sits in the top bit of the second header byte
    always_comb begin
        byte_nxt = rd_data;
        if (rd_idx_r == AW'(ts_out_pkg::TEI_BYTE)
                && error_flag_insert_enable && uncorr_r) begin
            byte_nxt = rd_data | ts_out_pkg::TEI_MASK;
        end
    end

    // Send side: a packet starts on the first launch edge once buffered,
    // so its position moves by at most one byte clock.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_r <= ts_out_pkg::ST_IDLE;
            rd_idx_r <= '0;
        end else if (CE_I) begin
            unique case (state_r)
                ts_out_pkg::ST_IDLE: begin
                    rd_idx_r <= '0;
                    if (start_ok) begin
                        state_r <= ts_out_pkg::ST_SEND;
                        rd_idx_r <= AW'(1);
                    end
                end
                ts_out_pkg::ST_SEND: begin
                    // Lost lock drops the packet so no tail leaks out later
                    if (!SYMBOL_LOCK_I) begin
                        state_r <= ts_out_pkg::ST_IDLE;
                        rd_idx_r <= '0;
                    end else if (launch) begin
                        if (rd_idx_r == LAST_IDX || stream_output_gate) begin
                            state_r <= ts_out_pkg::ST_IDLE;
                            rd_idx_r <= '0;
                        end else begin
                            rd_idx_r <= rd_idx_r + AW'(1);
                        end
                    end
                end
            endcase
        end
    end

    // Output pins follow the launch edge; lock loss idles them at once
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PACKET_BYTE_OUT_O <= 8'h00;
            PACKET_START_STROBE_O <= 1'b0;
            PACKET_VALID_STROBE_O <= 1'b0;
            BLOCK_ERROR_N_O <= 1'b1;
        end else if (CE_I && (launch || !SYMBOL_LOCK_I)) begin
            if (stream_output_gate || !SYMBOL_LOCK_I) begin
                PACKET_BYTE_OUT_O <= 8'h00;
                PACKET_START_STROBE_O <= 1'b0;
                PACKET_VALID_STROBE_O <= 1'b0;
                BLOCK_ERROR_N_O <= 1'b1;
            end else if (state_r == ts_out_pkg::ST_IDLE && start_ok) begin
                PACKET_BYTE_OUT_O <= rd_data;
                PACKET_START_STROBE_O <= 1'b1;
                PACKET_VALID_STROBE_O <= 1'b1;
                BLOCK_ERROR_N_O <= !uncorr_r;
            end else if (state_r == ts_out_pkg::ST_SEND) begin
                PACKET_BYTE_OUT_O <= byte_nxt;
                PACKET_START_STROBE_O <= 1'b0;
                PACKET_VALID_STROBE_O <= 1'b1;
                BLOCK_ERROR_N_O <= !uncorr_r;
            end else begin
                PACKET_BYTE_OUT_O <= 8'h00;
                PACKET_START_STROBE_O <= 1'b0;
                PACKET_VALID_STROBE_O <= 1'b0;
                BLOCK_ERROR_N_O <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [ts_packet_out_checker.sv]
// Port-level assertions for the transport packet output stage.
// Assumes binding to ts_packet_out; shadows the clock control register.
`timescale 1ns/1ps
`default_nettype none
module ts_packet_out_checker #(
    parameter int PKT_LEN = 188
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic SYMBOL_LOCK_I,
    input wire logic IN_VALID_I,
    input wire logic IN_READY_O,
    input wire logic REG_WE_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic OUTPUT_BYTE_CLOCK_O,
    input wire logic [7:0] PACKET_BYTE_OUT_O,
    input wire logic PACKET_START_STROBE_O,
    input wire logic PACKET_VALID_STROBE_O,
    input wire logic BLOCK_ERROR_N_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic [1:0] ctl_r;
    logic clk_q_r;
    logic [7:0] out_cnt_r;
    logic [7:0] fill_cnt_r;
    logic [5:0] stall_r;
    logic samp;
    // Receiver samples on the edge opposite to the launch edge
    assign samp = ctl_r[0] ? (OUTPUT_BYTE_CLOCK_O && !clk_q_r)
                           : (!OUTPUT_BYTE_CLOCK_O && clk_q_r);
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctl_r <= 2'h1;
        end else if (CE_I && REG_WE_I
                && REG_ADDR_I == ts_out_pkg::OUT_CLK_CTRL_OFF) begin
            ctl_r <= REG_WDATA_I[1:0];
        end
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            clk_q_r <= 1'b0;
        end else begin
            clk_q_r <= OUTPUT_BYTE_CLOCK_O;
        end
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            out_cnt_r <= 8'h00;
        end else if (samp) begin
            out_cnt_r <= !PACKET_VALID_STROBE_O ? 8'h00 :
                PACKET_START_STROBE_O ? 8'h01 : out_cnt_r + 8'h01;
        end
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fill_cnt_r <= 8'h00;
        end else if (CE_I && IN_VALID_I && IN_READY_O) begin
            fill_cnt_r <= (fill_cnt_r == PKT_LEN - 1) ? 8'h00
                                                      : fill_cnt_r + 8'h01;
        end
    end
    // User clock may legally stand still, so no stall count then
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            stall_r <= 6'h00;
        end else if (!SYMBOL_LOCK_I || !CE_I || ctl_r[1] ||
                     OUTPUT_BYTE_CLOCK_O != clk_q_r) begin
            stall_r <= 6'h00;
        end else begin
            stall_r <= stall_r + 6'h01;
        end
    end
    chk_start_in_valid: assert property (PACKET_START_STROBE_O |-> PACKET_VALID_STROBE_O)
        else $error("start strobe outside valid");
    chk_gap_data_low: assert property (!PACKET_VALID_STROBE_O |-> PACKET_BYTE_OUT_O == 8'h00)
        else $error("data not low between packets");
    // Lock loss idles the pins without a clock edge, so it is excluded
    chk_launch_edge: assert property ($past(SYMBOL_LOCK_I) && $changed({PACKET_BYTE_OUT_O, PACKET_START_STROBE_O, PACKET_VALID_STROBE_O, BLOCK_ERROR_N_O}) |-> (ctl_r[0] ? $fell(OUTPUT_BYTE_CLOCK_O) : $rose(OUTPUT_BYTE_CLOCK_O)))
        else $error("pins changed off the launch edge");
    chk_error_in_valid: assert property (!BLOCK_ERROR_N_O |-> PACKET_VALID_STROBE_O)
        else $error("block error outside packet");
    chk_error_steady: assert property ((PACKET_VALID_STROBE_O && !PACKET_START_STROBE_O) |-> $stable(BLOCK_ERROR_N_O))
        else $error("block error changed inside packet");
    chk_start_first: assert property ((samp && PACKET_START_STROBE_O) |-> (out_cnt_r == 0 || out_cnt_r == PKT_LEN))
        else $error("start strobe not on first byte");
    chk_valid_length: assert property ((samp && PACKET_VALID_STROBE_O && !PACKET_START_STROBE_O) |-> (out_cnt_r != 0 && out_cnt_r < PKT_LEN))
        else $error("packet longer than allowed");
    chk_ready_drop: assert property ((CE_I && IN_VALID_I && IN_READY_O && fill_cnt_r == PKT_LEN - 1) |=> !IN_READY_O)
        else $error("ready stayed high after full packet");
    chk_clock_held: assert property (!SYMBOL_LOCK_I [*3] |-> !OUTPUT_BYTE_CLOCK_O)
        else $error("byte clock running without lock");
    chk_clock_runs: assert property (stall_r < 6'h28)
        else $error("byte clock stopped while locked");
    cov_start: cover property (samp && PACKET_START_STROBE_O);
    cov_error: cover property (samp && !BLOCK_ERROR_N_O);
    cov_full: cover property (fill_cnt_r == PKT_LEN - 1 ##1 !IN_READY_O);
endmodule
bind ts_packet_out ts_packet_out_checker #(.PKT_LEN(PKT_LEN)) chk_i (.CLK_I,
    .RST_I, .CE_I, .SYMBOL_LOCK_I, .IN_VALID_I, .IN_READY_O, .REG_WE_I,
    .REG_ADDR_I, .REG_WDATA_I, .OUTPUT_BYTE_CLOCK_O, .PACKET_BYTE_OUT_O,
    .PACKET_START_STROBE_O, .PACKET_VALID_STROBE_O, .BLOCK_ERROR_N_O);
`default_nettype wire

// [ts_sink_model.sv]
// Downstream transport processor model: samples the byte-wide stream.
// Assumes the byte clock pin is oversampled by the core clock.
`timescale 1ns/1ps
`default_nettype none
module ts_sink_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic inv_i,
    input wire logic byte_clk_i,
    input wire logic [7:0] data_i,
    input wire logic start_i,
    input wire logic valid_i,
    input wire logic bk_n_i,
    output logic [7:0] pkts_o,
    output logic [7:0] len_o,
    output logic [7:0] b0_o,
    output logic [7:0] b1_o,
    output logic [7:0] blast_o,
    output logic [7:0] nbk_o
);
    logic clk_q;
    logic [7:0] idx;
    logic edge_seen;
    // Sample on the edge opposite the launch edge
    assign edge_seen = inv_i ? (byte_clk_i && !clk_q) : (!byte_clk_i && clk_q);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_q <= 1'b0;
            idx <= 8'h00;
            pkts_o <= 8'h00;
            len_o <= 8'h00;
            b0_o <= 8'h00;
            b1_o <= 8'h00;
            blast_o <= 8'h00;
            nbk_o <= 8'h00;
        end else begin
            clk_q <= byte_clk_i;
            // Stream is stable at the non-launch edge
            if (edge_seen && valid_i) begin
                idx <= start_i ? 8'h01 : idx + 8'h01;
                blast_o <= data_i;
                nbk_o <= (start_i ? 8'h00 : nbk_o) + {7'h00, !bk_n_i};
                if (start_i) begin
                    b0_o <= data_i;
                end
                if (!start_i && idx == 8'h01) begin
                    b1_o <= data_i;
                end
            end else if (edge_seen && idx != 8'h00) begin
                len_o <= idx;
                idx <= 8'h00;
                pkts_o <= pkts_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire
